// ===== include/usf_pkg.sv
package usf_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [4:0] ADDR_CONTROL_TWO   = 5'h08;
  localparam logic [4:0] ADDR_CONTROL_THREE = 5'h0c;
  localparam logic [4:0] ADDR_STATUS_ONE    = 5'h10;
  localparam logic [4:0] ADDR_STATUS_TWO    = 5'h14;
  localparam logic [4:0] ADDR_DATA_BUFFER   = 5'h18;

  // ==========================================================
  // Status one field positions
  localparam int ST1_TX_EMPTY    = 7;
  localparam int ST1_TX_COMPLETE = 6;
  localparam int ST1_RX_FULL     = 5;
  localparam int ST1_IDLE        = 4;
  localparam int ST1_OVERRUN     = 3;
  localparam int ST1_NOISE       = 2;
  localparam int ST1_FRAMING     = 1;
  localparam int ST1_PARITY      = 0;

  // ==========================================================
  // Status two field positions
  localparam int ST2_BREAK       = 1;
  localparam int ST2_RX_PROGRESS = 0;

  // ==========================================================
  // Control two field positions
  localparam int C2_TX_EMPTY_IE    = 7;
  localparam int C2_TX_COMPLETE_IE = 6;
  localparam int C2_RX_FULL_IE     = 5;
  localparam int C2_IDLE_IE        = 4;

  // ==========================================================
  // Control three field positions
  localparam int C3_NINTH_BIT  = 7;
  localparam int C3_OVERRUN_IE = 3;
  localparam int C3_NOISE_IE   = 2;
  localparam int C3_FRAMING_IE = 1;
  localparam int C3_PARITY_IE  = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_STATUS_ONE  = 8'hc0;
  localparam logic [1:0] RST_STATUS_TWO  = 2'h0;
  localparam logic [3:0] RST_CONTROL_TWO = 4'h0;
  localparam logic [3:0] RST_CONTROL_THR = 4'h0;

  // ==========================================================
  // Bus slave states
  typedef enum logic [0:0] {
    USF_BUS_IDLE   = 1'b0,
    USF_BUS_ANSWER = 1'b1
  } usf_bus_state_t;
endpackage

// ===== verilog/usf_status_buffer.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
// Contract
// RQ1: Tx-empty flag sets when buffer hands character to shifter; reset sets it.
// RQ2: Tx-empty clears after status-one read with flag set, then data write.
// RQ3: Tx-empty with its enable raises transmitter request.
// RQ4: Tx-complete sets when tx-empty set and nothing sending; reset sets it.
// RQ5: Tx-complete clears itself when data, preamble or break is queued.
// RQ6: Tx-complete with its enable raises transmitter request.
// RQ7: Rx-full sets on shifter-to-buffer transfer; requests receiver interrupt; reset clears.
// RQ8: Rx-full clears after status-one read with flag set, then data read.
// RQ9: Idle flag sets on idle line, requests if enabled, clears by sequence.
// RQ10: Idle flag rearms only after a valid character sets rx-full.
// RQ11: Character completing while buffer full sets overrun and is discarded.
// RQ12: Data read clears overrun only if set at preceding status-one read.
// RQ13: Overrun with its enable raises error request.
// RQ14: Noise flag sets on line noise, requests if enabled, clears by sequence.
// RQ15: Framing flag sets on zero stop bit, requests if enabled, clears by sequence.
// RQ16: Parity flag sets on parity failure, requests if enabled, clears by sequence.
// RQ17: Break sets break, framing, rx-full; clears ninth bit in nine-bit mode.
// RQ18: Break clears by status-two read then data read; rearms after line ones.
// RQ19: In-progress flag sets on first-slot zero, clears on false start or idle.
// RQ20: Data address reads received byte, writes byte to send; reset keeps contents.
// RQ21: Software avoids read-modify-write on the data buffer.
// RQ22: Ninth bit captured with data; eight-bit mode copies bit seven there.
// RQ23: Enabled flags merge into transmitter, receiver and error request lines.
module usf_status_buffer (
  input  wire logic        i_clk,             // 100 MHz bus clock
  input  wire logic        i_rst,             // Async reset, active high
  input  wire logic [4:0]  i_address,         // Avalon byte address
  input  wire logic        i_read,            // Avalon read
  input  wire logic        i_write,           // Avalon write
  input  wire logic [3:0]  i_byteenable,      // Avalon byte enables
  input  wire logic [31:0] i_writedata,       // Avalon write data
  output logic      [31:0] o_readdata,        // Avalon read data
  output logic             o_waitrequest,     // Avalon wait request
  input  wire logic        i_rxd,             // Receive data pin
  input  wire logic        i_rx_enable,       // Receiver enabled
  input  wire logic        i_nine_bit_mode,   // Nine-bit characters
  input  wire logic        i_rx_done,         // Character complete pulse
  input  wire logic [8:0]  i_rx_data,         // Received character
  input  wire logic        i_rx_noise,        // Noise seen, with done
  input  wire logic        i_rx_stop_zero,    // Zero stop bit, with done
  input  wire logic        i_rx_parity_err,   // Parity failure, with done
  input  wire logic        i_rx_break,        // Break character pulse
  input  wire logic        i_rx_idle,         // Idle character pulse
  input  wire logic        i_rx_start_zero,   // Zero in first sample slot
  input  wire logic        i_rx_false_start,  // False start pulse
  input  wire logic        i_tx_take,         // Shifter took buffer pulse
  input  wire logic        i_tx_busy,         // Data, preamble or break sending
  input  wire logic        i_tx_queue,        // Preamble or break queued pulse
  output logic      [7:0]  o_tx_data,         // Byte to transmit
  output logic             o_tx_pending,      // Buffer holds unsent byte
  output logic             o_tx_irq,          // Transmitter request
  output logic             o_rx_irq,          // Receiver request
  output logic             o_err_irq          // Error request
);
  import usf_pkg::*;

  // ==========================================================
  // Registers
  usf_bus_state_t bus_state_r;
  logic [7:0]  status_one_r;
  logic [1:0]  status_two_r;
  logic [3:0]  control_two_r;
  logic [3:0]  control_three_r;
  logic [7:0]  arm_one_r;
  logic        arm_break_r;
  logic [7:0]  rx_buf_r;
  logic        ninth_bit_r;
  logic        idle_armed_r;
  logic        break_armed_r;
  logic        rx_enable_r;
  logic [2:0]  rxd_sync_r;
  logic        rxd_level_r;
  logic [31:0] readdata_nxt;

  // ==========================================================
  // Bus decode
  logic take;
  logic rd_take;
  logic wr_take;
  logic data_rd;
  logic data_wr;
  logic st1_rd;
  logic st2_rd;
  logic rx_accept;
  logic rx_clear;
  logic tx_clear;

  assign take      = (bus_state_r == USF_BUS_ANSWER) && (i_read || i_write);
  assign rd_take   = take && i_read;
  assign wr_take   = take && i_write && i_byteenable[0];
  assign data_rd   = rd_take && (i_address == ADDR_DATA_BUFFER);
  assign data_wr   = wr_take && (i_address == ADDR_DATA_BUFFER);
  assign st1_rd    = rd_take && (i_address == ADDR_STATUS_ONE);
  assign st2_rd    = rd_take && (i_address == ADDR_STATUS_TWO);
  assign rx_clear  = data_rd && arm_one_r[ST1_RX_FULL];                                  // RQ8
  assign tx_clear  = data_wr && arm_one_r[ST1_TX_EMPTY];                                 // RQ2
  // Buffer free once emptied or being emptied this cycle
  assign rx_accept = i_rx_done && (!status_one_r[ST1_RX_FULL] || rx_clear);              // RQ11

  // ==========================================================
  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_state_r   <= USF_BUS_IDLE;
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_state_r)
        USF_BUS_IDLE: begin
          if (i_read || i_write) begin
            bus_state_r   <= USF_BUS_ANSWER;
            o_waitrequest <= 1'b0;
            o_readdata    <= i_read ? readdata_nxt : 32'h0000_0000;
          end
        end
        USF_BUS_ANSWER: begin
          bus_state_r   <= USF_BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_r   <= USF_BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    readdata_nxt = 32'h0000_0000;
    case (i_address)
      ADDR_CONTROL_TWO:   readdata_nxt[7:4] = control_two_r;
      ADDR_CONTROL_THREE: begin
        readdata_nxt[C3_NINTH_BIT] = ninth_bit_r;
        readdata_nxt[3:0]          = control_three_r;
      end
      ADDR_STATUS_ONE:    readdata_nxt[7:0] = status_one_r;
      ADDR_STATUS_TWO:    readdata_nxt[1:0] = status_two_r;
      ADDR_DATA_BUFFER:   readdata_nxt[7:0] = rx_buf_r;                                  // RQ20
      default:            readdata_nxt = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      control_two_r   <= RST_CONTROL_TWO;
      control_three_r <= RST_CONTROL_THR;
    end else begin
      if (wr_take && (i_address == ADDR_CONTROL_TWO)) begin
        control_two_r <= i_writedata[7:4];
      end
      if (wr_take && (i_address == ADDR_CONTROL_THREE)) begin
        control_three_r <= i_writedata[3:0];
      end
    end
  end

  // ==========================================================
  // Clear-sequence snapshot, taken from the value the read returned
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arm_one_r   <= 8'h00;
      arm_break_r <= 1'b0;
    end else begin
      if (st1_rd) begin
        arm_one_r <= o_readdata[7:0];                                                    // RQ12
      end else if (data_rd) begin
        arm_one_r <= {arm_one_r[7], 7'h00};
      end else if (data_wr) begin
        arm_one_r <= {1'b0, arm_one_r[6:0]};
      end
      if (st2_rd) begin
        arm_break_r <= o_readdata[ST2_BREAK];                                            // RQ18
      end else if (data_rd) begin
        arm_break_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmit pending byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_pending <= 1'b0;
    end else begin
      if (data_wr) begin
        o_tx_pending <= 1'b1;
      end else if (i_tx_take) begin
        o_tx_pending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Data buffer, untouched by reset
  always_ff @(posedge i_clk) begin
    if (data_wr) begin
      o_tx_data <= i_writedata[7:0];                                                     // RQ20
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rx_break && break_armed_r) begin
      rx_buf_r <= 8'h00;
      if (i_nine_bit_mode) begin
        ninth_bit_r <= 1'b0;                                                             // RQ17
      end
    end else if (rx_accept) begin
      rx_buf_r    <= i_rx_data[7:0];                                                     // RQ20
      ninth_bit_r <= i_nine_bit_mode ? i_rx_data[8] : i_rx_data[7];                      // RQ22
    end
  end

  // ==========================================================
  // Receive pin synchroniser and break rearm
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rxd_sync_r  <= 3'h7;
      rxd_level_r <= 1'b1;
    end else begin
      rxd_sync_r <= {rxd_sync_r[1:0], i_rxd};
      if (rxd_sync_r[1] == rxd_sync_r[2]) begin
        rxd_level_r <= rxd_sync_r[2];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      break_armed_r <= 1'b1;
    end else if (i_rx_break && break_armed_r) begin
      break_armed_r <= 1'b0;
    end else if (rxd_level_r && !status_two_r[ST2_BREAK]) begin
      break_armed_r <= 1'b1;                                                             // RQ18
    end
  end

  // ==========================================================
  // Status one flags; set wins over clear, except tx-complete, where a data write or queue wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_one_r <= RST_STATUS_ONE;                                                    // RQ1 RQ4 RQ7
    end else begin
      if (i_tx_take) begin
        status_one_r[ST1_TX_EMPTY] <= 1'b1;                                              // RQ1
      end else if (tx_clear) begin
        status_one_r[ST1_TX_EMPTY] <= 1'b0;                                              // RQ2
      end
      if (data_wr || i_tx_queue) begin
        status_one_r[ST1_TX_COMPLETE] <= 1'b0;                                           // RQ5
      end else if (status_one_r[ST1_TX_EMPTY] && !i_tx_busy && !o_tx_pending) begin
        status_one_r[ST1_TX_COMPLETE] <= 1'b1;                                           // RQ4
      end
      if (rx_accept || (i_rx_break && break_armed_r)) begin
        status_one_r[ST1_RX_FULL] <= 1'b1;                                               // RQ7 RQ17
      end else if (rx_clear) begin
        status_one_r[ST1_RX_FULL] <= 1'b0;                                               // RQ8
      end
      if (i_rx_idle && idle_armed_r) begin
        status_one_r[ST1_IDLE] <= 1'b1;                                                  // RQ9
      end else if (data_rd && arm_one_r[ST1_IDLE]) begin
        status_one_r[ST1_IDLE] <= 1'b0;                                                  // RQ9
      end
      if (i_rx_done && !rx_accept) begin
        status_one_r[ST1_OVERRUN] <= 1'b1;                                               // RQ11
      end else if (data_rd && arm_one_r[ST1_OVERRUN]) begin
        status_one_r[ST1_OVERRUN] <= 1'b0;                                               // RQ12
      end
      if (rx_accept && i_rx_noise) begin
        status_one_r[ST1_NOISE] <= 1'b1;                                                 // RQ14
      end else if (data_rd && arm_one_r[ST1_NOISE]) begin
        status_one_r[ST1_NOISE] <= 1'b0;                                                 // RQ14
      end
      if ((rx_accept && i_rx_stop_zero) || (i_rx_break && break_armed_r)) begin
        status_one_r[ST1_FRAMING] <= 1'b1;                                               // RQ15 RQ17
      end else if (data_rd && arm_one_r[ST1_FRAMING]) begin
        status_one_r[ST1_FRAMING] <= 1'b0;                                               // RQ15
      end
      if (rx_accept && i_rx_parity_err) begin
        status_one_r[ST1_PARITY] <= 1'b1;                                                // RQ16
      end else if (data_rd && arm_one_r[ST1_PARITY]) begin
        status_one_r[ST1_PARITY] <= 1'b0;                                                // RQ16
      end
    end
  end

  // ==========================================================
  // Idle arming and status two
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_armed_r <= 1'b0;
      rx_enable_r  <= 1'b0;
    end else begin
      rx_enable_r <= i_rx_enable;
      if (rx_accept) begin
        idle_armed_r <= 1'b1;                                                            // RQ10
      end else if ((i_rx_enable && !rx_enable_r) || (i_rx_idle && idle_armed_r)) begin
        idle_armed_r <= 1'b0;                                                            // RQ10
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_two_r <= RST_STATUS_TWO;
    end else begin
      if (i_rx_break && break_armed_r) begin
        status_two_r[ST2_BREAK] <= 1'b1;                                                 // RQ17
      end else if (data_rd && arm_break_r) begin
        status_two_r[ST2_BREAK] <= 1'b0;                                                 // RQ18
      end
      if (i_rx_start_zero) begin
        status_two_r[ST2_RX_PROGRESS] <= 1'b1;                                           // RQ19
      end else if (i_rx_false_start || i_rx_idle) begin
        status_two_r[ST2_RX_PROGRESS] <= 1'b0;                                           // RQ19
      end
    end
  end

  // ==========================================================
  // Request lines; break and in-progress never request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_irq  <= 1'b0;
      o_rx_irq  <= 1'b0;
      o_err_irq <= 1'b0;
    end else begin
      o_tx_irq  <= (status_one_r[ST1_TX_EMPTY] && control_two_r[C2_TX_EMPTY_IE - 4])     // RQ3
                || (status_one_r[ST1_TX_COMPLETE] && control_two_r[C2_TX_COMPLETE_IE - 4]); // RQ6
      o_rx_irq  <= (status_one_r[ST1_RX_FULL] && control_two_r[C2_RX_FULL_IE - 4])       // RQ7
                || (status_one_r[ST1_IDLE] && control_two_r[C2_IDLE_IE - 4]);             // RQ9 RQ23
      o_err_irq <= |(status_one_r[3:0] & control_three_r);                               // RQ13 RQ14 RQ15 RQ16 RQ23
    end
  end

endmodule

// ===== dv/usf_far_end.sv
`timescale 1ns/1ps
// ====================
// Line and engine stand-in
module usf_far_end (
  input  wire logic       i_clk,            // Clock
  output logic            o_rxd,            // Line level
  output logic            o_rx_done,        // Character done
  output logic      [8:0] o_rx_data,        // Character
  output logic            o_rx_noise,       // Noise
  output logic            o_rx_stop_zero,   // Zero stop bit
  output logic            o_rx_parity_err,  // Parity failure
  output logic            o_rx_break,       // Break
  output logic            o_rx_idle,        // Idle character
  output logic            o_rx_start_zero,  // Start slot zero
  output logic            o_rx_false_start, // False start
  output logic            o_tx_take,        // Shifter take
  output logic            o_tx_busy,        // Sending
  output logic            o_tx_queue        // Preamble queued
);
  logic [5:0] ev_r = 6'h0;
  assign {o_tx_queue, o_tx_take, o_rx_false_start, o_rx_start_zero, o_rx_idle, o_rx_break} = ev_r;
  initial begin
    o_rxd = 1'b1;
    o_rx_done = 1'b0;
    o_rx_data = 9'h0;
    {o_rx_noise, o_rx_stop_zero, o_rx_parity_err} = 3'h0;
    o_tx_busy = 1'b0;
  end
  // Qualifiers show garbage outside the done cycle
  task automatic char(input logic [8:0] d, input logic [2:0] e);
    @(posedge i_clk);
    o_rx_data <= d;
    {o_rx_noise, o_rx_stop_zero, o_rx_parity_err} <= e;
    o_rx_done <= 1'b1;
    @(posedge i_clk);
    o_rx_done <= 1'b0;
    o_rx_data <= ~d;
    {o_rx_noise, o_rx_stop_zero, o_rx_parity_err} <= ~e;
  endtask
  // 0 break, 1 idle, 2 start, 3 false start, 4 take, 5 queue
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev_r[k] <= 1'b1;
    if (k == 0) begin
      o_rxd <= 1'b0;
    end
    if (k >= 4) begin
      o_tx_busy <= 1'b1;
    end
    @(posedge i_clk);
    ev_r <= 6'h0;
  endtask
  task automatic line_idle;
    @(posedge i_clk);
    o_rxd <= 1'b1;
    o_tx_busy <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

// ===== dv/usf_status_buffer_asserts.sv
`timescale 1ns/1ps
// ====================
// Bus and flag checker
module usf_status_buffer_asserts (
  input wire logic        i_clk,         // Clock
  input wire logic        i_rst,         // Reset
  input wire logic [4:0]  i_address,     // Address
  input wire logic        i_read,        // Read
  input wire logic        i_write,       // Write
  input wire logic [3:0]  i_byteenable,  // Byte enables
  input wire logic [31:0] i_writedata,   // Write data
  input wire logic [31:0] o_readdata,    // Read data
  input wire logic        o_waitrequest, // Wait request
  input wire logic        i_rx_done,     // Character done
  input wire logic        i_rx_break,    // Break
  input wire logic        i_rx_idle,     // Idle
  input wire logic        i_tx_take,     // Shifter take
  input wire logic [7:0]  o_tx_data,     // Byte to send
  input wire logic        o_tx_pending,  // Unsent byte
  input wire logic        o_rx_irq,      // Receiver request
  input wire logic        o_err_irq      // Error request
);
  import usf_pkg::*;
  logic acc;
  logic dwr;
  assign acc = !o_waitrequest && (i_read || i_write);
  assign dwr = acc && i_write && i_address == ADDR_DATA_BUFFER && i_byteenable[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ans_one_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("wait not one cycle");
  idle_wait_a: assert property (o_waitrequest && !(i_read || i_write) |=> o_waitrequest)
    else $error("answer without request");
  rd_unmapped_a: assert property (acc && i_read && i_address == 5'h1c |-> o_readdata == 32'h0)
    else $error("unmapped read");
  rd_width_a: assert property (acc && i_read && i_address == ADDR_STATUS_TWO |-> o_readdata[31:2] == 30'h0)
    else $error("status two high bits");
  tx_load_a: assert property (dwr && !i_tx_take |=> o_tx_data == $past(i_writedata[7:0]) && o_tx_pending)
    else $error("write not loaded");
  tx_taken_a: assert property (i_tx_take && !dwr |=> !o_tx_pending)
    else $error("pending after take");
  pend_drop_a: assert property ($fell(o_tx_pending) |-> $past(i_tx_take))
    else $error("pending fell early");
  rx_rise_a: assert property ($rose(o_rx_irq) |-> $past(i_rx_done || i_rx_break || i_rx_idle || acc, 2))
    else $error("rx request rose");
  rx_fall_a: assert property ($fell(o_rx_irq) |-> $past(acc, 2))
    else $error("rx request fell");
  err_rise_a: assert property ($rose(o_err_irq) |-> $past(i_rx_done || i_rx_break || acc, 2))
    else $error("error request rose");
  cover property (i_rx_done && o_rx_irq);
  cover property (dwr);
  cover property ($rose(o_err_irq));
endmodule
bind usf_status_buffer usf_status_buffer_asserts i_usf_status_buffer_asserts (.*);

// ===== dv/usf_status_buffer_tb_top.sv
`timescale 1ns/1ps
module usf_status_buffer_tb_top;
  import usf_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [4:0]  i_address = 5'h0;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [3:0]  i_byteenable = 4'hf;
  logic [31:0] i_writedata = 32'h0;
  logic        i_rx_enable = 1'b0;
  logic        i_nine_bit_mode = 1'b1;
  logic [31:0] o_readdata;
  logic [8:0]  i_rx_data;
  logic [7:0]  o_tx_data;
  logic        o_waitrequest, o_tx_pending, o_tx_irq, o_rx_irq, o_err_irq, i_rxd, i_rx_done, i_rx_noise;
  logic        i_rx_stop_zero, i_rx_parity_err, i_rx_break, i_rx_idle, i_rx_start_zero, i_rx_false_start;
  logic        i_tx_take, i_tx_busy, i_tx_queue;
  int          errors = 0;
  int          checks_done = 0;
  usf_status_buffer i_usf_status_buffer (.*);
  usf_far_end i_usf_far_end (.i_clk, .o_rxd(i_rxd), .o_rx_done(i_rx_done), .o_rx_data(i_rx_data),
    .o_rx_noise(i_rx_noise), .o_rx_stop_zero(i_rx_stop_zero), .o_rx_parity_err(i_rx_parity_err),
    .o_rx_break(i_rx_break), .o_rx_idle(i_rx_idle), .o_rx_start_zero(i_rx_start_zero),
    .o_rx_false_start(i_rx_false_start), .o_tx_take(i_tx_take), .o_tx_busy(i_tx_busy), .o_tx_queue(i_tx_queue));
  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Single reads and writes only, never read-modify-write
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      results();
    end
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic clr(input logic [7:0] s, input logic [7:0] d);
    rd(ADDR_STATUS_ONE, {24'h0, s});
    rd(ADDR_DATA_BUFFER, {24'h0, d});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // ====================
  // Scenarios
  task automatic t_reset;
    rd(ADDR_STATUS_ONE, 32'hc0);
    rd(ADDR_STATUS_TWO, 32'h0);
    rd(5'h1c, 32'h0);
    wr(ADDR_STATUS_ONE, 8'h00);
    rd(ADDR_STATUS_ONE, 32'hc0);
    $display("reset done");
  endtask
  task automatic t_tx;
    wr(ADDR_CONTROL_TWO, 8'h80);
    tick(2);
    chk(o_tx_irq, 1);
    rd(ADDR_STATUS_ONE, 32'hc0);
    wr(ADDR_DATA_BUFFER, 8'h5a);
    tick(2);
    chk({o_tx_pending, o_tx_data}, 32'h15a);
    chk(o_tx_irq, 0);
    rd(ADDR_STATUS_ONE, 32'h0);
    i_usf_far_end.pulse(4);
    rd(ADDR_STATUS_ONE, 32'h80);
    i_usf_far_end.line_idle();
    rd(ADDR_STATUS_ONE, 32'hc0);
    wr(ADDR_DATA_BUFFER, 8'ha5);
    rd(ADDR_STATUS_ONE, 32'h0);
    wr(ADDR_CONTROL_TWO, 8'h40);
    i_usf_far_end.pulse(4);
    tick(2);
    chk(o_tx_irq, 0);
    i_usf_far_end.line_idle();
    chk(o_tx_irq, 1);
    i_usf_far_end.pulse(5);
    rd(ADDR_STATUS_ONE, 32'h80);
    i_usf_far_end.line_idle();
    $display("tx done");
  endtask
  task automatic t_rx;
    wr(ADDR_CONTROL_TWO, 8'h20);
    i_usf_far_end.char(9'h125, 3'h0);
    tick(2);
    chk(o_rx_irq, 1);
    rd(ADDR_CONTROL_THREE, 32'h80);
    clr(8'he0, 8'h25);
    rd(ADDR_STATUS_ONE, 32'hc0);
    chk(o_rx_irq, 0);
    i_nine_bit_mode <= 1'b0;
    i_usf_far_end.char(9'h0a5, 3'h0);
    rd(ADDR_CONTROL_THREE, 32'h80);
    clr(8'he0, 8'ha5);
    i_nine_bit_mode <= 1'b1;
    $display("rx done");
  endtask
  task automatic t_idle;
    i_rx_enable <= 1'b0;
    wr(ADDR_CONTROL_TWO, 8'h10);
    i_rx_enable <= 1'b1;
    i_usf_far_end.pulse(2);
    rd(ADDR_STATUS_TWO, 32'h1);
    i_usf_far_end.pulse(1);
    rd(ADDR_STATUS_TWO, 32'h0);
    rd(ADDR_STATUS_ONE, 32'hc0);
    i_usf_far_end.pulse(2);
    i_usf_far_end.pulse(3);
    rd(ADDR_STATUS_TWO, 32'h0);
    i_usf_far_end.char(9'h011, 3'h0);
    i_usf_far_end.pulse(1);
    tick(2);
    chk(o_rx_irq, 1);
    clr(8'hf0, 8'h11);
    i_usf_far_end.pulse(1);
    rd(ADDR_STATUS_ONE, 32'hc0);
    $display("idle done");
  endtask
  task automatic t_over;
    wr(ADDR_CONTROL_THREE, 8'h08);
    i_usf_far_end.char(9'h011, 3'h0);
    i_usf_far_end.char(9'h022, 3'h0);
    tick(2);
    chk(o_err_irq, 1);
    clr(8'he8, 8'h11);
    i_usf_far_end.char(9'h044, 3'h0);
    rd(ADDR_STATUS_ONE, 32'he0);
    i_usf_far_end.char(9'h055, 3'h0);
    rd(ADDR_DATA_BUFFER, 32'h44);
    clr(8'hc8, 8'h44);
    rd(ADDR_STATUS_ONE, 32'hc0);
    $display("overrun done");
  endtask
  task automatic t_err;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONTROL_THREE, 8'(1 << i));
      i_usf_far_end.char(9'h033, 3'(1 << i));
      tick(2);
      chk(o_err_irq, 1);
      clr(8'he0 | 8'(1 << i), 8'h33);
      tick(2);
      chk(o_err_irq, 0);
    end
    $display("error done");
  endtask
  task automatic t_break;
    wr(ADDR_CONTROL_THREE, 8'h00);
    i_usf_far_end.char(9'h100, 3'h0);
    clr(8'he0, 8'h00);
    i_usf_far_end.pulse(0);
    rd(ADDR_STATUS_TWO, 32'h2);
    rd(ADDR_CONTROL_THREE, 32'h0);
    clr(8'he2, 8'h00);
    rd(ADDR_STATUS_TWO, 32'h0);
    i_usf_far_end.pulse(0);
    rd(ADDR_STATUS_TWO, 32'h0);
    i_usf_far_end.line_idle();
    i_usf_far_end.pulse(0);
    rd(ADDR_STATUS_TWO, 32'h2);
    clr(8'he2, 8'h00);
    rd(ADDR_STATUS_TWO, 32'h0);
    $display("break done");
  endtask
  task automatic t_rerst;
    i_usf_far_end.char(9'h13c, 3'h0);
    i_rst <= 1'b1;
    tick(3);
    i_rst <= 1'b0;
    i_byteenable <= 4'he;
    wr(ADDR_DATA_BUFFER, 8'h00);
    i_byteenable <= 4'hf;
    rd(ADDR_STATUS_ONE, 32'hc0);
    chk(o_tx_data, 32'ha5);
    rd(ADDR_CONTROL_THREE, 32'h80);
    rd(ADDR_DATA_BUFFER, 32'h3c);
    $display("second reset done");
  endtask
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    i_rx_enable <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_idle();
    t_over();
    t_err();
    t_break();
    t_rerst();
    results();
  end
endmodule
